/* File: rtl/port8_pkg.sv */
/*
 * Package for the eight-bit port with timer pin sharing: register offsets,
 * reset values, pin positions and the timer select codes.
 * Assumes a 32-bit AXI4-Lite register bus and one 20 MHz clock.
 */
package port8_pkg;
    localparam int PORT_W = 8;
    localparam int CHAN_N = 4;
    localparam logic [11:0] OFS_DIRECTION = 12'h000;
    localparam logic [11:0] OFS_LATCH = 12'h004;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam int PIN_EXT_CLK = 0;
    localparam int PIN_CHAN_A = 1;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // One channel's select field from the timer, with its output value
    typedef struct packed {
        logic [2:0] io_sel;
        logic out_val;
    } chan_ctrl_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wr_state_t;

    // Select 001 or 01x hands the pin to the timer as an output
    function automatic logic timer_owns(input logic [2:0] sel);
        return (sel == 3'h1) || (sel[2:1] == 2'h1);
    endfunction
endpackage

/* File: rtl/port8_gpio_timer_pin_mux.sv */
/*
 * Eight-bit general I/O port whose pins 1 to 4 may be taken over by the
 * timer's capture/compare channels and whose pin 0 always feeds the timer's
 * external clock input. Registers over AXI4-Lite.
 * Assumes pin inputs are asynchronous and the timer runs on clk.
 */
`timescale 1ns/1ps
`default_nettype none
module port8_gpio_timer_pin_mux
    import port8_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite write address and data
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Port pins
    input wire logic [PORT_W-1:0] pin_in,
    output logic [PORT_W-1:0] pin_out,
    output logic [PORT_W-1:0] pin_oe,
    // Timer side: channels a to d then levels back
    input wire chan_ctrl_t chan_ctrl [CHAN_N],
    output logic [CHAN_N-1:0] timer_chan_in,
    output logic timer_ext_clock_in
);
    logic [PORT_W-1:0] sync1_r;
    logic [PORT_W-1:0] sync2_r;
    logic [PORT_W-1:0] dir_r;
    logic [PORT_W-1:0] dir_nxt;
    logic [PORT_W-1:0] latch_r;
    logic [PORT_W-1:0] latch_nxt;
    logic [PORT_W-1:0] own_mask;
    logic [PORT_W-1:0] own_val;
    logic [PORT_W-1:0] oe_nxt;
    logic [PORT_W-1:0] out_nxt;
    logic [PORT_W-1:0] pin_out_r;
    logic [PORT_W-1:0] pin_oe_r;
    logic [PORT_W-1:0] latch_view;
    wr_state_t wr_state_r;
    logic [11:0] awaddr_r;
    logic aw_have_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_have_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // Two-flop synchroniser on all pin inputs
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    // Timer ownership per pin; only channel pins 1..4 can be claimed
    always_comb begin
        own_mask = '0;
        own_val = '0;
        for (int i = 0; i < CHAN_N; i++) begin
            own_mask[PIN_CHAN_A+i] = timer_owns(chan_ctrl[i].io_sel);
            own_val[PIN_CHAN_A+i] = chan_ctrl[i].out_val;
        end
    end

    assign oe_nxt = (own_mask & {PORT_W{1'b1}}) | (~own_mask & dir_r);
    assign out_nxt = (own_mask & own_val) | (~own_mask & latch_r & dir_r);

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_oe_r <= '0;
            pin_out_r <= '0;
        end else begin
            pin_oe_r <= oe_nxt;
            pin_out_r <= out_nxt;
        end
    end
    assign pin_oe = pin_oe_r;
    assign pin_out = pin_out_r;

    // Pin drive checks
    oe_reset_a: assert property (@(posedge clk)
        rst |=> pin_oe == '0 && pin_out == '0)
        else $error("pins not released by reset");
    input_off_a: assert property (@(posedge clk) disable iff (rst)
        !dir_r[PORT_W-2] && !own_mask[PORT_W-2] |=> !pin_oe[PORT_W-2] && !pin_out[PORT_W-2])
        else $error("input pin driven");
    pin0_out_a: assert property (@(posedge clk) disable iff (rst)
        pin_out[PIN_EXT_CLK] == $past(dir_r[PIN_EXT_CLK] & latch_r[PIN_EXT_CLK]))
        else $error("clock pin output not from latch");
    plain_out_a: assert property (@(posedge clk) disable iff (rst)
        pin_out[PORT_W-1:PIN_CHAN_A+CHAN_N] == $past(dir_r[PORT_W-1:PIN_CHAN_A+CHAN_N]
        & latch_r[PORT_W-1:PIN_CHAN_A+CHAN_N]))
        else $error("upper pin output not from latch");
    chan_zero_a: assert property (@(posedge clk) disable iff (rst)
        chan_ctrl[2].io_sel == 3'h0 |=> pin_oe[PIN_CHAN_A+2] == $past(dir_r[PIN_CHAN_A+2])
        && pin_out[PIN_CHAN_A+2] == $past(dir_r[PIN_CHAN_A+2] & latch_r[PIN_CHAN_A+2]))
        else $error("port lost control on select 000");
    chan_high_a: assert property (@(posedge clk) disable iff (rst)
        chan_ctrl[3].io_sel[2] |=> pin_oe[PIN_CHAN_A+3] == $past(dir_r[PIN_CHAN_A+3])
        && pin_out[PIN_CHAN_A+3] == $past(dir_r[PIN_CHAN_A+3] & latch_r[PIN_CHAN_A+3]))
        else $error("port output lost on select 1xx");
    chan_b_out_a: assert property (@(posedge clk) disable iff (rst)
        chan_ctrl[1].io_sel[2:1] == 2'h1 |=> pin_oe[PIN_CHAN_A+1]
        && pin_out[PIN_CHAN_A+1] == $past(chan_ctrl[1].out_val))
        else $error("timer output not driven on select 01x");
    chan_c_out_a: assert property (@(posedge clk) disable iff (rst)
        chan_ctrl[2].io_sel == 3'h1 |=> pin_oe[PIN_CHAN_A+2]
        && pin_out[PIN_CHAN_A+2] == $past(chan_ctrl[2].out_val))
        else $error("timer output not driven on select 001");

    // Levels always go back to the timer, whatever the direction
    assign timer_chan_in = sync2_r[PIN_CHAN_A +: CHAN_N];
    assign timer_ext_clock_in = sync2_r[PIN_EXT_CLK];

    // Latch read view: stored bit for outputs, pin level for inputs
    assign latch_view = (dir_r & latch_r) | (~dir_r & sync2_r);

    // Write channel: take address and data in either order
    logic do_write;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit_dir;
    logic wr_hit_latch;
    assign s_axi_awready = (wr_state_r == WR_IDLE) && !aw_have_r;
    assign s_axi_wready = (wr_state_r == WR_IDLE) && !w_have_r;
    assign wr_addr = aw_have_r ? awaddr_r : s_axi_awaddr;
    assign wr_data = w_have_r ? wdata_r : s_axi_wdata;
    assign wr_strb = w_have_r ? wstrb_r : s_axi_wstrb;
    assign do_write = (wr_state_r == WR_IDLE)
        && (aw_have_r || s_axi_awvalid) && (w_have_r || s_axi_wvalid);
    assign wr_hit_dir = (wr_addr[11:2] == OFS_DIRECTION[11:2]);
    assign wr_hit_latch = (wr_addr[11:2] == OFS_LATCH[11:2]);
    assign dir_nxt = (do_write && wr_hit_dir && wr_strb[0]) ? wr_data[7:0] : dir_r;
    assign latch_nxt = (do_write && wr_hit_latch && wr_strb[0]) ? wr_data[7:0] : latch_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            dir_r <= DIR_RESET;
            latch_r <= LATCH_RESET;
        end else begin
            dir_r <= dir_nxt;
            latch_r <= latch_nxt;
        end
    end

    // Register write checks
    dir_write_a: assert property (@(posedge clk) disable iff (rst)
        do_write && wr_hit_dir && wr_strb[0] |=> dir_r == $past(wr_data[PORT_W-1:0]))
        else $error("direction write not taken");
    latch_write_a: assert property (@(posedge clk) disable iff (rst)
        do_write && wr_hit_latch && wr_strb[0] |=> latch_r == $past(wr_data[PORT_W-1:0]))
        else $error("latch write not taken");
    strb_off_a: assert property (@(posedge clk) disable iff (rst)
        do_write && !wr_strb[0] |=> dir_r == $past(dir_r) && latch_r == $past(latch_r))
        else $error("write without byte strobe changed a register");
    reg_hold_a: assert property (@(posedge clk) disable iff (rst)
        !do_write |=> dir_r == $past(dir_r) && latch_r == $past(latch_r))
        else $error("register changed without a write");
    resp_ok_a: assert property (@(posedge clk) disable iff (rst)
        do_write && (wr_hit_dir || wr_hit_latch) |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
        else $error("mapped write not answered okay");
    resp_err_a: assert property (@(posedge clk) disable iff (rst)
        do_write && !wr_hit_dir && !wr_hit_latch |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write not refused");

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_state_r <= WR_IDLE;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bresp_r <= RESP_OKAY;
        end else begin
            unique case (wr_state_r)
                WR_IDLE: begin
                    if (do_write) begin
                        wr_state_r <= WR_RESP;
                        aw_have_r <= 1'b0;
                        w_have_r <= 1'b0;
                        bresp_r <= (wr_hit_dir || wr_hit_latch) ? RESP_OKAY : RESP_SLVERR;
                    end else begin
                        if (s_axi_awvalid && !aw_have_r) begin
                            aw_have_r <= 1'b1;
                            awaddr_r <= s_axi_awaddr;
                        end
                        if (s_axi_wvalid && !w_have_r) begin
                            w_have_r <= 1'b1;
                            wdata_r <= s_axi_wdata;
                            wstrb_r <= s_axi_wstrb;
                        end
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_r <= WR_IDLE;
                    end
                end
            endcase
        end
    end
    assign s_axi_bvalid = (wr_state_r == WR_RESP);
    assign s_axi_bresp = bresp_r;

    // Read channel; direction register is write-only and reads as zero
    logic rd_hit_dir;
    logic rd_hit_latch;
    assign s_axi_arready = !rvalid_r;
    assign rd_hit_dir = (s_axi_araddr[11:2] == OFS_DIRECTION[11:2]);
    assign rd_hit_latch = (s_axi_araddr[11:2] == OFS_LATCH[11:2]);

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_hit_latch ? {24'h000000, latch_view} : 32'h00000000;
            rresp_r <= (rd_hit_dir || rd_hit_latch) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // Read answer checks
    read_ok_a: assert property (@(posedge clk) disable iff (rst)
        s_axi_arvalid && s_axi_arready && (rd_hit_dir || rd_hit_latch) |=>
        s_axi_rvalid && s_axi_rresp == RESP_OKAY)
        else $error("mapped read not answered okay");
    read_upper_a: assert property (@(posedge clk) disable iff (rst)
        s_axi_rvalid |-> s_axi_rdata[31:PORT_W] == '0)
        else $error("unused read bits not zero");

    // Checks
    dir_drive_a: assert property (@(posedge clk) disable iff (rst)
        !own_mask[PORT_W-1] ##1 1'b1 |-> pin_oe[PORT_W-1] == $past(dir_r[PORT_W-1]))
        else $error("upper pin enable does not follow direction");
    dir_reset_a: assert property (@(posedge clk)
        rst |=> dir_r == DIR_RESET && latch_r == LATCH_RESET)
        else $error("registers not reset");
    dir_read_a: assert property (@(posedge clk) disable iff (rst)
        s_axi_rvalid && $rose(s_axi_rvalid) && $past(rd_hit_dir) |-> s_axi_rdata == 32'h0)
        else $error("direction read not zero");
    latch_out_a: assert property (@(posedge clk) disable iff (rst)
        dir_r[7] |=> pin_out[7] == $past(latch_r[7]))
        else $error("latch not driven on output pin");
    read_latch_a: assert property (@(posedge clk) disable iff (rst)
        s_axi_arvalid && s_axi_arready && rd_hit_latch |=>
        s_axi_rdata[7:0] == $past((dir_r & latch_r) | (~dir_r & sync2_r)))
        else $error("latch read view wrong");
    read_pin_a: assert property (@(posedge clk) disable iff (rst)
        s_axi_arvalid && s_axi_arready && rd_hit_latch && dir_r[5] == 1'b0 |=>
        s_axi_rdata[5] == $past(sync2_r[5]))
        else $error("input pin level not read");
    timer_wins_a: assert property (@(posedge clk) disable iff (rst)
        chan_ctrl[0].io_sel[2:1] == 2'h1 |=> pin_oe[PIN_CHAN_A])
        else $error("timer select did not take pin");
    timer_out_a: assert property (@(posedge clk) disable iff (rst)
        chan_ctrl[3].io_sel == 3'h1 |=> pin_out[4] == $past(chan_ctrl[3].out_val))
        else $error("timer output not driven");
    port_keep_a: assert property (@(posedge clk) disable iff (rst)
        chan_ctrl[1].io_sel[2] |=> pin_oe[2] == $past(dir_r[2]))
        else $error("port lost control on select 1xx");
    clk_pin_a: assert property (@(posedge clk) disable iff (rst)
        pin_oe[PIN_EXT_CLK] == $past(dir_r[PIN_EXT_CLK]) &&
        timer_ext_clock_in == sync2_r[PIN_EXT_CLK])
        else $error("clock pin override or routing wrong");
    plain_io_a: assert property (@(posedge clk) disable iff (rst)
        pin_oe[7:5] == $past(dir_r[7:5]))
        else $error("upper pins not plain I/O");
endmodule
`default_nettype wire

/* File: tb/board_model.sv */
/*
 Board-side model of the eight port pins.
 Assumes pin_oe high means the block drives the pin.
*/
`timescale 1ns/1ps
`default_nettype none
module board_model
    import port8_pkg::*;
(
    // Block side
    input wire logic [PORT_W-1:0] pin_out,
    input wire logic [PORT_W-1:0] pin_oe,
    // Level the board puts on pins the block leaves free
    input wire logic [PORT_W-1:0] ext_lvl,
    output logic [PORT_W-1:0] pin_in
);
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule
`default_nettype wire

/* File: tb/port8_gpio_timer_pin_mux_tb.sv */
/*
 Self-checking bench for the port with timer pin sharing.
 Assumes the hand-over latencies: pins settle within four clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module port8_gpio_timer_pin_mux_tb;
    import port8_pkg::*;
    logic clk = 0;
    logic rst = 1;
    logic [11:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, tclk;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp;
    logic [7:0] pin_in, pin_out, pin_oe, ext_lvl = 8'h00;
    logic [3:0] tci;
    chan_ctrl_t chan_ctrl [CHAN_N] = '{default: '0};
    int fail_count = 0;
    int checks = 0;
    port8_gpio_timer_pin_mux i_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .chan_ctrl(chan_ctrl), .timer_chan_in(tci), .timer_ext_clock_in(tclk));
    board_model i_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
        .pin_in(pin_in));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic finish_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tmo(logic ok);
        if (ok !== 1'b1) begin
            chk("bus answer", 1, 0);
            finish_test();
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 50);
        tmo(bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 50);
        tmo(rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic t_gpio;
        logic [31:0] d;
        logic [1:0] r;
        chk("oe at reset", 8'h00, pin_oe);
        rd(OFS_DIRECTION, d, r);
        chk("dir read", 32'h0, d);
        chk("dir read resp", RESP_OKAY, r);
        ext_lvl <= 8'h3c;
        wr(OFS_DIRECTION, 32'hff, r);
        chk("dir write resp", RESP_OKAY, r);
        rd(OFS_LATCH, d, r);
        chk("latch reset", 32'h0, d);
        wr(OFS_LATCH, 32'ha5, r);
        tick(2);
        chk("oe all", 8'hff, pin_oe);
        chk("out all", 8'ha5, pin_out);
        wr(OFS_DIRECTION, 32'hf0, r);
        tick(4);
        chk("oe half", 8'hf0, pin_oe);
        rd(OFS_LATCH, d, r);
        chk("mixed read", 32'hac, d);
        wstrb <= 4'h0;
        wr(OFS_LATCH, 32'h00, r);
        wstrb <= 4'hf;
        chk("strobe off resp", RESP_OKAY, r);
        rd(OFS_LATCH, d, r);
        chk("strobe off", 32'hac, d);
        wr(12'h008, 32'h0, r);
        chk("unmapped", RESP_SLVERR, r);
    endtask
    task automatic t_timer;
        logic own;
        ext_lvl <= 8'h0a;
        for (int s = 0; s < 8; s++) begin
            @(posedge clk);
            for (int c = 0; c < CHAN_N; c++) chan_ctrl[c] <= '{io_sel: 3'(s), out_val: 1'b1};
            tick(4);
            own = (s == 1) || (s == 2) || (s == 3);
            chk("chan oe", own ? 4'hf : 4'h8, pin_oe[4:1]);
            chk("chan in", own ? 4'hf : 4'h5, tci);
            chk("plain oe", 3'h7, pin_oe[7:5]);
        end
    endtask
    task automatic t_pin0;
        logic [1:0] r;
        @(posedge clk);
        ext_lvl <= 8'h0b;
        tick(4);
        chk("ext clk in", 1'b1, tclk);
        wr(OFS_LATCH, 32'ha4, r);
        wr(OFS_DIRECTION, 32'hf1, r);
        tick(4);
        chk("pin0 oe", 1'b1, pin_oe[0]);
        chk("ext clk out", 1'b0, tclk);
        chk("plain out", 3'h5, pin_out[7:5]);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        t_gpio();
        t_timer();
        t_pin0();
        finish_test();
    end
endmodule
`default_nettype wire
